// *** test_route_consts.vh ***
/*
  Constants for the digital test signal router: register indices, field
  positions, reset values, unlock code and live-code masks.
  Assumes it is included by its bare name from every design file.
*/
`ifndef TEST_ROUTE_CONSTS_VH
`define TEST_ROUTE_CONSTS_VH

// ==========================================================================
// Register indices (byte address is four times the index)
`define IDX_UNLOCK        8'h40
`define IDX_ROUTE_A       8'h4B
`define IDX_ROUTE_B       8'h4C
`define IDX_ROUTE_C       8'h4D
`define IDX_STATUS        8'h4E

// ==========================================================================
// Reset values and the unlock code (code value is arbitrary)
`define ROUTE_RESET       8'h00
`define UNLOCK_RESET      8'h00
`define UNLOCK_CODE       8'h5A

// ==========================================================================
// Nibble fields of each routing register
`define HI_MSB            7
`define HI_LSB            4
`define LO_MSB            3
`define LO_LSB            0
`define CODE_NORMAL       4'h0

// ==========================================================================
// Fixed burst pin selections
`define BURST_CAL_OVF     4'h6
`define BURST_BAUD_CLK    4'hB
`define BURST_CRC_FAIL    4'hA
`define BURST_WDOG_RST    4'h1

// ==========================================================================
// Live-code masks: bit k high means code k carries a real signal
`define LIVE_CLOCK_PIN    16'hDFFE
`define LIVE_OPT_PIN      16'hFFFE
`define LIVE_INT_PIN      16'hFFFE
`define LIVE_BURST_PIN    16'hFEFE
`define LIVE_SELECT_PIN   16'h3FFE

// ==========================================================================
// Status register bit positions
`define ST_UNLOCKED       0
`define ST_CLOCK_TEST     1
`define ST_OPT_TEST       2
`define ST_INT_TEST       3
`define ST_BURST_TEST     4
`define ST_SELECT_TEST    5

`endif

// *** route_mux.v ***
/*
  One pin's test selector: code zero passes the pin's normal function,
  any other code passes the matching internal signal or a constant low.
  Assumes the code register and sources are synchronous to pclk.
*/
`timescale 1ns/1ps
`include "test_route_consts.vh"

module route_mux #(
  parameter [15:0] LIVE_MASK = 16'hFFFE
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // Selection and signals
  input  wire [3:0]  code,
  input  wire        normal_in,
  input  wire [15:0] sources,
  // Pin drive
  output reg         pin_out
);

  reg pin_next;

  // Dead codes give a steady low so a stray selection cannot toggle a pin
  always @* begin
    if (code == `CODE_NORMAL) begin
      pin_next = normal_in;
    end else begin
      pin_next = sources[code] & LIVE_MASK[code];
    end
  end

  // Registered so the pin never glitches while the code changes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 1'b0;
    end else begin
      pin_out <= pin_next;
    end
  end

endmodule // route_mux

// *** access_guard.v ***
/*
  Holds the unlock register and reports whether it carries the code.
  Assumes writes arrive as a one-cycle enable from the bus slave.
*/
`timescale 1ns/1ps
`include "test_route_consts.vh"

module access_guard (
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Write port
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  // State
  output reg  [7:0] unlock_reg,
  output wire       unlocked
);

  // Reset relocks the test registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_reg <= `UNLOCK_RESET;
    end else if (wr_en) begin
      unlock_reg <= wr_data;
    end
  end

  // Gates new routing writes and feeds status bit 0; existing selections do not look here
  assign unlocked = (unlock_reg == `UNLOCK_CODE);

endmodule // access_guard

// *** digital_test_signal_mux.v ***
/*
  Digital test signal router behind an APB slave. Three routing registers
  steer internal signals onto five pins instead of their normal function,
  writable only while the unlock register carries the code.
  Assumes an APB master on pclk, synchronous internal sources, and that
  the pin pads take the registered pin outputs directly.
*/
// Summary of operation
// - A written selection keeps routing its signal until rewritten or reset.
// - Changing the unlock code later leaves stored selections untouched.
// - Register A bits 7:4 pick the clock pin signal, bits 3:0 the optional pin, 0000 normal.
// - Each nonzero code replaces the pin's normal output with its one assigned signal, or with a steady low if the code is dead.
// - Register B bits 7:4 pick the interrupt pin signal, bits 3:0 the burst pin, 0000 normal.
// - Burst codes 0110, 1011, 1010, 0001 give cal overflow, baud clock, CRC fail, watchdog.
// - Register C bits 7:4 route self-test and status signals to the select pin; 3:0 reserved.
`timescale 1ns/1ps
`include "test_route_consts.vh"

module digital_test_signal_mux #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input  wire              pclk,
  input  wire              presetn,
  // APB slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  input  wire [3:0]        pstrb,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // Normal pin functions
  input  wire              sys_clock_normal,
  input  wire              opt_data_normal,
  input  wire              interrupt_normal,
  input  wire              burst_normal,
  input  wire              data_select_normal,
  // Test sources, bit k is the signal for code k
  input  wire [15:0]       clock_pin_sources,
  input  wire [15:0]       opt_pin_sources,
  input  wire [15:0]       interrupt_sources,
  input  wire [15:0]       burst_other_sources,
  input  wire [15:0]       select_pin_sources,
  // Burst pin signals with fixed codes
  input  wire              pll_cal_overflow,
  input  wire              baud_clock,
  input  wire              crc_failed,
  input  wire              watchdog_reset,
  // Routed pins
  output wire              sys_clock_pin,
  output wire              opt_data_pin,
  output wire              interrupt_pin,
  output wire              burst_pin,
  output wire              data_select_pin
);

  // ========================================================================
  // Register selector codes
  localparam [2:0] SEL_NONE   = 3'd0;
  localparam [2:0] SEL_UNLOCK = 3'd1;
  localparam [2:0] SEL_A      = 3'd2;
  localparam [2:0] SEL_B      = 3'd3;
  localparam [2:0] SEL_C      = 3'd4;
  localparam [2:0] SEL_STATUS = 3'd5;

  // Reset value as a vector, so register C can take just its stored nibble
  localparam [7:0] ROUTE_RST  = `ROUTE_RESET;

  // ========================================================================
  // Declarations
  reg  [7:0]  route_a_reg;
  reg  [7:0]  route_b_reg;
  reg  [3:0]  route_c_reg;
  reg  [31:0] rdata_next;
  reg         slverr_next;
  reg  [15:0] burst_sources;
  wire [7:0]  unlock_reg;
  wire        unlocked;
  wire        access;
  wire        done;
  wire [2:0]  rd_sel;
  wire        wr_ok;
  wire        route_wr_ok;
  wire        wr_unlock;
  wire        wr_a;
  wire        wr_b;
  wire        wr_c;
  wire [7:0]  status_byte;

  // ========================================================================
  // Address decode; misaligned or unknown addresses fall out as none
  function [2:0] reg_sel;
    input [ADDR_W-1:0] a;
    begin
      if (a[1:0] != 2'b00) begin
        reg_sel = SEL_NONE;
      end else if (a[ADDR_W-1:2] == `IDX_UNLOCK) begin
        reg_sel = SEL_UNLOCK;
      end else if (a[ADDR_W-1:2] == `IDX_ROUTE_A) begin
        reg_sel = SEL_A;
      end else if (a[ADDR_W-1:2] == `IDX_ROUTE_B) begin
        reg_sel = SEL_B;
      end else if (a[ADDR_W-1:2] == `IDX_ROUTE_C) begin
        reg_sel = SEL_C;
      end else if (a[ADDR_W-1:2] == `IDX_STATUS) begin
        reg_sel = SEL_STATUS;
      end else begin
        reg_sel = SEL_NONE;
      end
    end
  endfunction

  // Nonzero code means the pin is under test; shared by the five pin status bits
  function code_live;
    input [3:0] c;
    begin
      code_live = (c != `CODE_NORMAL);
    end
  endfunction

  // ========================================================================
  // APB handshake: one wait state, the transfer ends when pready is high
  assign access = psel & penable;
  assign done   = access & pready;
  assign rd_sel = reg_sel(paddr);

  // Writes act only at the completing edge and only through byte lane 0
  assign wr_ok       = done & pwrite & pstrb[0];
  // Locked writes are simply dropped, the bus still completes normally
  assign route_wr_ok = wr_ok & unlocked;

  // One strobe per register, so each register process tests a single net
  assign wr_unlock = wr_ok & (rd_sel == SEL_UNLOCK);
  assign wr_a      = route_wr_ok & (rd_sel == SEL_A);
  assign wr_b      = route_wr_ok & (rd_sel == SEL_B);
  assign wr_c      = route_wr_ok & (rd_sel == SEL_C);

  // Ready rises one cycle into the access phase and falls with it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access & ~pready;
    end
  end

  // ========================================================================
  // Unlock register lives in its own guard
  access_guard u_guard (
    .pclk       (pclk),
    .presetn    (presetn),
    .wr_en      (wr_unlock),
    .wr_data    (pwdata[7:0]),
    .unlock_reg (unlock_reg),
    .unlocked   (unlocked)
  );

  // ========================================================================
  // Routing register A: clock pin and optional data pin
  // Only a new write changes it, the unlock state is not consulted again
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_a_reg <= `ROUTE_RESET;
    end else if (wr_a) begin
      route_a_reg <= pwdata[7:0];
    end
  end

  // Routing register B: interrupt pin and burst pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_b_reg <= `ROUTE_RESET;
    end else if (wr_b) begin
      route_b_reg <= pwdata[7:0];
    end
  end

  // Routing register C: select pin; the low nibble is reserved, not stored
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_c_reg <= ROUTE_RST[`HI_MSB:`HI_LSB];
    end else if (wr_c) begin
      route_c_reg <= pwdata[`HI_MSB:`HI_LSB];
    end
  end

  // ========================================================================
  // Status byte: unlock state and which pins are under test
  assign status_byte = {2'b00,
                        code_live(route_c_reg),
                        code_live(route_b_reg[`LO_MSB:`LO_LSB]),
                        code_live(route_b_reg[`HI_MSB:`HI_LSB]),
                        code_live(route_a_reg[`LO_MSB:`LO_LSB]),
                        code_live(route_a_reg[`HI_MSB:`HI_LSB]),
                        unlocked};

  // ========================================================================
  // Read mux; unmapped addresses read zero and flag an error
  always @* begin
    rdata_next  = 32'h00000000;
    slverr_next = 1'b0;
    if (rd_sel == SEL_UNLOCK) begin
      rdata_next[7:0] = unlock_reg;
    end else if (rd_sel == SEL_A) begin
      rdata_next[7:0] = route_a_reg;
    end else if (rd_sel == SEL_B) begin
      rdata_next[7:0] = route_b_reg;
    end else if (rd_sel == SEL_C) begin
      rdata_next[7:0] = {route_c_reg, 4'h0};
    end else if (rd_sel == SEL_STATUS) begin
      rdata_next[7:0] = status_byte;
    end else begin
      slverr_next = 1'b1;
    end
  end

  // Answer is latched as pready rises, so it is stable for the whole cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      prdata  <= pwrite ? 32'h00000000 : rdata_next;
      pslverr <= slverr_next;
    end else begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // ========================================================================
  // Burst sources with the four fixed-code signals patched in
  always @* begin
    burst_sources                  = burst_other_sources;
    burst_sources[`BURST_CAL_OVF]  = pll_cal_overflow;
    burst_sources[`BURST_BAUD_CLK] = baud_clock;
    burst_sources[`BURST_CRC_FAIL] = crc_failed;
    burst_sources[`BURST_WDOG_RST] = watchdog_reset;
  end

  // ========================================================================
  // Pin selectors: upper nibble of A drives the clock pin
  route_mux #(
    .LIVE_MASK (`LIVE_CLOCK_PIN)
  ) u_clock_pin (
    .pclk      (pclk),
    .presetn   (presetn),
    .code      (route_a_reg[`HI_MSB:`HI_LSB]),
    .normal_in (sys_clock_normal),
    .sources   (clock_pin_sources),
    .pin_out   (sys_clock_pin)
  );

  // Lower nibble of A drives the optional data pin
  route_mux #(
    .LIVE_MASK (`LIVE_OPT_PIN)
  ) u_opt_pin (
    .pclk      (pclk),
    .presetn   (presetn),
    .code      (route_a_reg[`LO_MSB:`LO_LSB]),
    .normal_in (opt_data_normal),
    .sources   (opt_pin_sources),
    .pin_out   (opt_data_pin)
  );

  // Upper nibble of B drives the interrupt pin
  route_mux #(
    .LIVE_MASK (`LIVE_INT_PIN)
  ) u_interrupt_pin (
    .pclk      (pclk),
    .presetn   (presetn),
    .code      (route_b_reg[`HI_MSB:`HI_LSB]),
    .normal_in (interrupt_normal),
    .sources   (interrupt_sources),
    .pin_out   (interrupt_pin)
  );

  // Lower nibble of B drives the burst pin; code 1000 is dead
  route_mux #(
    .LIVE_MASK (`LIVE_BURST_PIN)
  ) u_burst_pin (
    .pclk      (pclk),
    .presetn   (presetn),
    .code      (route_b_reg[`LO_MSB:`LO_LSB]),
    .normal_in (burst_normal),
    .sources   (burst_sources),
    .pin_out   (burst_pin)
  );

  // Upper nibble of C drives the select pin; codes 1110 and 1111 are dead
  route_mux #(
    .LIVE_MASK (`LIVE_SELECT_PIN)
  ) u_select_pin (
    .pclk      (pclk),
    .presetn   (presetn),
    .code      (route_c_reg),
    .normal_in (data_select_normal),
    .sources   (select_pin_sources),
    .pin_out   (data_select_pin)
  );

endmodule // digital_test_signal_mux

// *** pin_source.sv ***
/* Far side of the router: normal pin functions and internal sources.
   Assumes the router samples them on the rising edge of pclk. */
`timescale 1ns/1ps
module pin_source (
  // Clock
  input  logic        pclk,
  // Normal functions: clock, optional, interrupt, burst, select
  output logic [4:0]  nrm,
  // Sources per pin, bit k for code k
  output logic [15:0] sc,
  output logic [15:0] so,
  output logic [15:0] si,
  output logic [15:0] sb,
  output logic [15:0] ss,
  // Fixed burst signals: cal overflow, baud, crc, watchdog
  output logic [3:0]  fx
);
  // ==========================================================
  // Fresh values after every edge, so a stuck route shows up
  initial {nrm, sc, so, si, sb, ss, fx} = 89'h0;
  always @(posedge pclk) begin
    {nrm, sc, so, si, sb, ss, fx} <= 89'({$urandom(), $urandom(), $urandom()});
  end
endmodule // pin_source

// *** route_sva.sv ***
/* Checker for the test signal router: register answers and pin routes.
   Assumes binding to the router top; shadows follow completed writes. */
`timescale 1ns/1ps
`include "test_route_consts.vh"
module route_sva #(
  parameter ADDR_W = 12
) (
  // Clock, reset and APB
  input logic              pclk,
  input logic              presetn,
  input logic              psel,
  input logic              penable,
  input logic              pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [31:0]       pwdata,
  input logic [3:0]        pstrb,
  input logic [31:0]       prdata,
  input logic              pready,
  input logic              pslverr,
  // Pins and their sources
  input logic              sys_clock_normal,
  input logic [15:0]       clock_pin_sources,
  input logic              sys_clock_pin,
  input logic              interrupt_normal,
  input logic              interrupt_pin,
  input logic              burst_normal,
  input logic [15:0]       burst_other_sources,
  input logic              pll_cal_overflow,
  input logic              baud_clock,
  input logic              crc_failed,
  input logic              watchdog_reset,
  input logic              burst_pin,
  input logic              data_select_pin
);
  // ==========================================================
  // Shadow registers, updated only by writes that should land
  localparam [15:0] LC = `LIVE_CLOCK_PIN;
  localparam [15:0] LB = `LIVE_BURST_PIN;
  wire       done = psel && penable && pready;
  wire       rdn  = done && !pwrite;
  reg  [7:0] unl_reg, a_reg, b_reg, c_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {unl_reg, a_reg, b_reg, c_reg} <= 32'h0;
    end else if (done && pwrite && pstrb[0]) begin
      if (paddr == 12'h100) unl_reg <= pwdata[7:0];
      if (unl_reg == `UNLOCK_CODE && paddr == 12'h12C) a_reg <= pwdata[7:0];
      if (unl_reg == `UNLOCK_CODE && paddr == 12'h130) b_reg <= pwdata[7:0];
      if (unl_reg == `UNLOCK_CODE && paddr == 12'h134) c_reg <= pwdata[7:0];
    end
  end
  // Expected pin values before the pad register
  wire [15:0] bsrc = {burst_other_sources[15:12], baud_clock, crc_failed,
                      burst_other_sources[9:7], pll_cal_overflow,
                      burst_other_sources[5:2], watchdog_reset, burst_other_sources[0]};
  wire cexp = (a_reg[7:4] == 4'h0) ? sys_clock_normal
            : (clock_pin_sources[a_reg[7:4]] & LC[a_reg[7:4]]);
  wire bexp = (b_reg[3:0] == 4'h0) ? burst_normal : (bsrc[b_reg[3:0]] & LB[b_reg[3:0]]);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Routing, one edge behind code and source
  property p_clk; $past(presetn) |-> sys_clock_pin == $past(cexp); endproperty
  a_clk: assert property (p_clk) else $error("clock pin route wrong");
  property p_int;
    $past(presetn) && $past(b_reg[7:4]) == 4'h0 |-> interrupt_pin == $past(interrupt_normal);
  endproperty
  a_int: assert property (p_int) else $error("interrupt pin not normal");
  property p_brst; $past(presetn) |-> burst_pin == $past(bexp); endproperty
  a_brst: assert property (p_brst) else $error("burst pin route wrong");
  property p_dead; $past(presetn) && $past(c_reg[7:4]) >= 4'hE |-> !data_select_pin; endproperty
  a_dead: assert property (p_dead) else $error("undefined code not low");
  // Read answers
  property p_rda; rdn && paddr == 12'h12C |-> prdata == {24'h0, a_reg}; endproperty
  a_rda: assert property (p_rda) else $error("selection lost");
  property p_rdc; rdn && paddr == 12'h134 |-> prdata == {24'h0, c_reg[7:4], 4'h0}; endproperty
  a_rdc: assert property (p_rdc) else $error("select register readback wrong");
  property p_st;
    rdn && paddr == 12'h138 |-> prdata == {26'h0, |c_reg[7:4], |b_reg[3:0], |b_reg[7:4],
                                           |a_reg[3:0], |a_reg[7:4], unl_reg == `UNLOCK_CODE};
  endproperty
  a_st: assert property (p_st) else $error("status flags wrong");
  property p_err;
    done && !(paddr inside {12'h100, 12'h12C, 12'h130, 12'h134, 12'h138}) |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access without error");
endmodule // route_sva

bind digital_test_signal_mux route_sva #(.ADDR_W(ADDR_W)) sva (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .pslverr, .sys_clock_normal, .clock_pin_sources, .sys_clock_pin, .interrupt_normal,
  .interrupt_pin, .burst_normal, .burst_other_sources, .pll_cal_overflow, .baud_clock,
  .crc_failed, .watchdog_reset, .burst_pin, .data_select_pin);

// *** tb_top.sv ***
/* Self-checking bench for the test signal router: APB tasks, pin compare.
   Assumes pin_source drives all sources and the checker is bound. */
`timescale 1ns/1ps
`include "test_route_consts.vh"
module tb_top;
  // ==========================================================
  // Signals
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  pstrb = 4'h0, fx;
  logic        pready, pslverr;
  logic [4:0]  nrm, pin, epin;
  logic [15:0] sc, so, si, sb, ss;
  logic [7:0]  unl, ra, rb, rc;
  int          n_mismatch = 0, n_tests = 0, cyc = 0;
  localparam logic [11:0] UA = {2'h0, `IDX_UNLOCK, 2'h0}, RA = {2'h0, `IDX_ROUTE_A, 2'h0};
  localparam logic [11:0] RB = {2'h0, `IDX_ROUTE_B, 2'h0}, RC = {2'h0, `IDX_ROUTE_C, 2'h0};
  localparam logic [11:0] RS = {2'h0, `IDX_STATUS, 2'h0};
  always #25 pclk = ~pclk;
  pin_source src (.pclk, .nrm, .sc, .so, .si, .sb, .ss, .fx);
  digital_test_signal_mux #(.ADDR_W(12)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .sys_clock_normal(nrm[0]), .opt_data_normal(nrm[1]),
    .interrupt_normal(nrm[2]), .burst_normal(nrm[3]), .data_select_normal(nrm[4]),
    .clock_pin_sources(sc), .opt_pin_sources(so), .interrupt_sources(si),
    .burst_other_sources(sb), .select_pin_sources(ss), .pll_cal_overflow(fx[0]),
    .baud_clock(fx[1]), .crc_failed(fx[2]), .watchdog_reset(fx[3]),
    .sys_clock_pin(pin[0]), .opt_data_pin(pin[1]), .interrupt_pin(pin[2]),
    .burst_pin(pin[3]), .data_select_pin(pin[4]));
  // ==========================================================
  // Expectations and reporting
  function automatic logic rt(input logic [3:0] c, input logic n, input logic [15:0] s,
                              input logic [15:0] m);
    return (c == 4'h0) ? n : (s[c] & m[c]);
  endfunction
  function automatic logic [7:0] st();
    return {2'h0, |rc[7:4], |rb[3:0], |rb[7:4], |ra[3:0], |ra[7:4], unl == `UNLOCK_CODE};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Pads register their selection, so the model lags one edge too
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) epin <= 5'h00;
    else epin <= {rt(rc[7:4], nrm[4], ss, `LIVE_SELECT_PIN),
                  rt(rb[3:0], nrm[3], {sb[15:12], fx[1], fx[2], sb[9:7], fx[0], sb[5:2],
                                       fx[3], sb[0]}, `LIVE_BURST_PIN),
                  rt(rb[7:4], nrm[2], si, `LIVE_INT_PIN),
                  rt(ra[3:0], nrm[1], so, `LIVE_OPT_PIN),
                  rt(ra[7:4], nrm[0], sc, `LIVE_CLOCK_PIN)};
  end
  // Mid-cycle compare, well clear of the edge
  always @(negedge pclk) begin
    check(32'(pin[0]), 32'(epin[0]));
    check(32'(pin[1]), 32'(epin[1]));
    check(32'(pin[2]), 32'(epin[2]));
    check(32'(pin[3]), 32'(epin[3]));
    check(32'(pin[4]), 32'(epin[4]));
  end
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ==========================================================
  // APB master: hold the request until pready is sampled high
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r, output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge pclk);
    penable <= 1'b1;
    // No assumed wait count; only the hang guard ends a stuck access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
    logic [31:0] r, w;
    logic        e;
    w = $urandom();
    w[7:0] = d;
    xfer(a, 1'b1, w, s, r, e);
    if (s[0] && a == UA) unl <= d;
    if (s[0] && unl == `UNLOCK_CODE) begin
      if (a == RA) ra <= d;
      if (a == RB) rb <= d;
      if (a == RC) rc <= {d[7:4], 4'h0};
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic er);
    logic [31:0] r;
    logic        e;
    xfer(a, 1'b0, $urandom(), 4'h0, r, e);
    check(r, {24'h0, x});
    check(32'(e), 32'(er));
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    {unl, ra, rb, rc} <= 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    logic [11:0] a;
    void'($urandom(51016));
    do_reset();
    rd(RS, 8'h00, 1'b0);
    wr(RA, 8'h37, 4'hF);
    rd(RA, 8'h00, 1'b0);
    // Every code through every nibble, back to back after unlocking
    wr(UA, `UNLOCK_CODE, 4'h1);
    for (int i = 0; i < 16; i++) begin
      wr(RA, {4'(i), 4'(15 - i)}, 4'h1);
      wr(RB, {4'(15 - i), 4'(i)}, 4'h1);
      wr(RC, {4'(i), 4'hF}, 4'h1);
      repeat (3) @(posedge pclk);
      rd(RC, {4'(i), 4'h0}, 1'b0);
      rd(RS, st(), 1'b0);
    end
    // Relocking keeps the selection and drops later writes
    wr(RA, 8'hD6, 4'h1);
    wr(UA, 8'h00, 4'h1);
    wr(RA, 8'h12, 4'h1);
    rd(RA, 8'hD6, 1'b0);
    wr(UA, `UNLOCK_CODE, 4'hE);
    rd(RS, st(), 1'b0);
    rd(12'h104, 8'h00, 1'b1);
    rd(12'h12D, 8'h00, 1'b1);
    // Random traffic with the unlock code coming and going
    for (int i = 0; i < 40; i++) begin
      a = (i % 3 == 0) ? UA : RA + 12'(4 * ($urandom() % 3));
      wr(a, ($urandom() % 2) ? `UNLOCK_CODE : 8'($urandom()), 4'($urandom()));
      // Let the model's write land before its value becomes the expectation
      @(posedge pclk);
      rd(RB, rb, 1'b0);
    end
    do_reset();
    rd(RB, 8'h00, 1'b0);
    stop_test();
  end
endmodule // tb_top
